// [common/phy_init_pkg.sv]
// constants, types and sequence table shared by both ends of the phy init link
package phy_init_pkg;
  localparam int unsigned NUM_PORTS = 5;
  localparam logic [2:0] FIRST_PORT = 3'h1;
  localparam logic [3:0] PHY_WIN_NIBBLE = 4'h1;
  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_MMD_SETUP = 5'h0d;
  localparam logic [4:0] REG_MMD_DATA = 5'h0e;
  localparam logic [15:0] CTRL_FORCE_100FD = 16'h2100;
  localparam logic [15:0] CTRL_AN_RESTART = 16'h1340;
  localparam int unsigned CTRL_AN_EN_BIT = 12;
  localparam int unsigned CTRL_RESTART_BIT = 9;
  localparam logic [1:0] MMD_FN_ADDR = 2'h0;
  localparam logic [1:0] MMD_FN_DATA = 2'h1;
  localparam logic [7:0] MMD_DEV_PMA = 8'h01;
  localparam logic [7:0] MMD_DEV_VEND = 8'h1c;
  localparam logic [7:0] MMD_UNFIXED_REG = 8'h08;
  localparam logic [4:0] AN_EN_RST = 5'h1f;
  localparam logic [4:0] STEP_LAST = 5'h1d;
  localparam logic [2:0] INBAND_PORT_DEF = 3'h7;
  typedef enum logic [1:0] {
    PATH_MDIO = 2'h0,
    PATH_I2C = 2'h1,
    PATH_SPI = 2'h2,
    PATH_INBAND = 2'h3
  } mgmt_path_t;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PORT_MASK = 8'h08;
  localparam logic [1:0] CTRL_PATH_RST = 2'h0;
  localparam logic [4:0] PORT_MASK_RST = 5'h1f;

  // devad, register, value of the receive tuning list, in issue order
  function automatic logic [31:0] mmd_entry(input logic [2:0] idx);
    case (idx)
      3'h0: mmd_entry = {8'h01, 8'h6f, 16'hdd0b};
      3'h1: mmd_entry = {8'h01, 8'h8f, 16'h6032};
      3'h2: mmd_entry = {8'h01, 8'h9d, 16'h248c};
      3'h3: mmd_entry = {8'h01, 8'h75, 16'h0060};
      3'h4: mmd_entry = {8'h01, 8'hd3, 16'h7777};
      3'h5: mmd_entry = {8'h1c, 8'h06, 16'h3008};
      default: mmd_entry = {8'h1c, 8'h08, 16'h2000};
    endcase
  endfunction : mmd_entry

  // byte address of standard phy register r of port p
  function automatic logic [15:0] phy_addr(input logic [2:0] p, input logic [4:0] r);
    phy_addr = {1'b0, p, PHY_WIN_NIBBLE, 2'h0, r, 1'b0};
  endfunction : phy_addr
endpackage : phy_init_pkg

// [common/mgmt_if.sv]
// management access link between the init sequencer and the switch register space
`timescale 1ns/1ps
interface mgmt_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [15:0] wdata;
  phy_init_pkg::mgmt_path_t path;
  logic [2:0] ib_port;
  logic ack;
  logic err;
  logic [15:0] rdata;
  modport cfg (output req, output we, output addr, output wdata, output path, output ib_port,
               input ack, input err, input rdata);
  modport dev (input req, input we, input addr, input wdata, input path, input ib_port,
               output ack, output err, output rdata);
endinterface : mgmt_if

// [design/ahb_cfg_slave.sv]
// ahb-lite slave for the sequencer control registers
`timescale 1ns/1ps
module ahb_cfg_slave (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // ahb-lite
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // register side
  output logic o_wr,
  output logic [7:0] o_wofs,
  output logic [31:0] o_wdata,
  input wire logic [31:0] i_rd_ctrl,
  input wire logic [31:0] i_rd_status,
  input wire logic [31:0] i_rd_mask
);
  logic aphase;
  logic wpend_q, wpend_d;
  logic [7:0] wofs_q, wofs_d;
  logic [31:0] hrdata_q, hrdata_d;

  always_comb begin
    // only whole aligned words; other sizes are ignored but still answered okay
    aphase = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'h2) & (i_haddr[1:0] == 2'h0);
    wpend_d = aphase & i_hwrite;
    wofs_d = aphase ? i_haddr[7:0] : wofs_q;
    hrdata_d = hrdata_q;
    if (aphase & ~i_hwrite) begin
      case (i_haddr[7:0])
        phy_init_pkg::OFS_CTRL: hrdata_d = i_rd_ctrl;
        phy_init_pkg::OFS_STATUS: hrdata_d = i_rd_status;
        phy_init_pkg::OFS_PORT_MASK: hrdata_d = i_rd_mask;
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wpend_q <= 1'b0;
      wofs_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wpend_q <= wpend_d;
      wofs_q <= wofs_d;
      hrdata_q <= hrdata_d;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // write lands at the end of the data phase, so only a read whose address phase comes after that sees it
  assign o_wr = wpend_q;
  assign o_wofs = wofs_q;
  assign o_wdata = i_hwdata;
  assign o_hrdata = hrdata_q;
endmodule : ahb_cfg_slave

// [design/phy_cfg_device.sv]
// switch side: phy register window, mmd indirect access and path checks
`timescale 1ns/1ps
module phy_cfg_device #(
  parameter int unsigned NUM_PORTS = phy_init_pkg::NUM_PORTS,
  parameter logic [2:0] INBAND_PORT = phy_init_pkg::INBAND_PORT_DEF
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // management link
  mgmt_if.dev m,
  // phy state
  output logic [NUM_PORTS-1:0] o_an_enable,
  output logic [NUM_PORTS-1:0] o_an_restart,
  output logic o_mmd_wr
);
  logic [15:0] std_mem [0:255];
  logic [15:0] mmd_mem [0:4095];
  logic ack_q, ack_d, err_q, err_d, unfix_q, mmd_wr_q, mmd_wr_d;
  logic [15:0] rdata_q, rdata_d;
  logic [NUM_PORTS-1:0] an_en_q, an_en_d, rst_q, rst_d;
  logic fire, hit, path_ok, wr_ok, dev_known, data_mode;
  logic [2:0] port_n, pidx;
  logic [4:0] rnum;
  logic [15:0] setup, ptr;
  logic [11:0] midx;

  always_comb begin
    port_n = m.addr[14:12];
    pidx = port_n - 3'h1;
    rnum = m.addr[5:1];
    fire = m.req & ~ack_q;
    hit = ~m.addr[15] & (port_n >= phy_init_pkg::FIRST_PORT) & (32'(port_n) <= NUM_PORTS)
          & (m.addr[11:8] == phy_init_pkg::PHY_WIN_NIBBLE) & (m.addr[7:6] == 2'h0) & ~m.addr[0];
    path_ok = (m.path != phy_init_pkg::PATH_INBAND) || (m.ib_port == INBAND_PORT);
    wr_ok = fire & hit & path_ok & m.we;
    setup = std_mem[{pidx, phy_init_pkg::REG_MMD_SETUP}];
    ptr = std_mem[{pidx, 5'h1f}];
    data_mode = setup[15:14] != phy_init_pkg::MMD_FN_ADDR;
    dev_known = (setup[7:0] == phy_init_pkg::MMD_DEV_PMA) || (setup[7:0] == phy_init_pkg::MMD_DEV_VEND);
    midx = {pidx, setup[7:0] == phy_init_pkg::MMD_DEV_VEND, ptr[7:0]};
    ack_d = fire;
    err_d = fire & ~(hit & path_ok);
    rdata_d = rdata_q;
    if (fire & hit & path_ok & ~m.we) begin
      rdata_d = std_mem[{pidx, rnum}];
      if (rnum == phy_init_pkg::REG_MMD_DATA && data_mode) begin
        rdata_d = dev_known ? mmd_mem[midx] : 16'h0000;
        if (setup[7:0] == phy_init_pkg::MMD_DEV_VEND && ptr[7:0] == phy_init_pkg::MMD_UNFIXED_REG)
          rdata_d[0] = unfix_q;
      end
    end
    an_en_d = an_en_q;
    rst_d = '0;
    if (wr_ok && rnum == phy_init_pkg::REG_BASIC_CTRL) begin
      an_en_d[pidx] = m.wdata[phy_init_pkg::CTRL_AN_EN_BIT];
      rst_d[pidx] = m.wdata[phy_init_pkg::CTRL_RESTART_BIT];
    end
    mmd_wr_d = wr_ok & (rnum == phy_init_pkg::REG_MMD_DATA) & data_mode & dev_known;
  end

  // register 0x1f of each port row holds the mmd pointer; it is not a phy register
  always_ff @(posedge i_mclk) begin
    if (wr_ok && rnum != 5'h1f) begin
      std_mem[{pidx, rnum}] <= m.wdata;
    end
    if (wr_ok && rnum == phy_init_pkg::REG_MMD_DATA) begin
      if (!data_mode)
        std_mem[{pidx, 5'h1f}] <= m.wdata;
      else if (dev_known)
        mmd_mem[midx] <= m.wdata;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 16'h0000;
      unfix_q <= 1'b0;
      an_en_q <= NUM_PORTS'(phy_init_pkg::AN_EN_RST);
      rst_q <= '0;
      mmd_wr_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      err_q <= err_d;
      rdata_q <= rdata_d;
      unfix_q <= ~unfix_q;
      an_en_q <= an_en_d;
      rst_q <= rst_d;
      mmd_wr_q <= mmd_wr_d;
    end
  end

  assign m.ack = ack_q;
  assign m.err = err_q;
  assign m.rdata = rdata_q;
  assign o_an_enable = an_en_q;
  assign o_an_restart = rst_q;
  assign o_mmd_wr = mmd_wr_q;
endmodule : phy_cfg_device

// [design/phy_init_host.sv]
// configuring end: walks every selected phy port through the receive tuning sequence
//
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module phy_init_host #(
  parameter int unsigned NUM_PORTS = phy_init_pkg::NUM_PORTS
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // ahb-lite
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // management link
  mgmt_if.cfg m,
  // progress
  output logic o_busy,
  output logic o_done
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_END = 4'b1000
  } seq_state_t;

  seq_state_t state_q, state_d;
  logic [2:0] port_q, port_d;
  logic [4:0] step_q, step_d;
  logic rd_q, rd_d;
  logic req_q, req_d;
  logic we_q, we_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic err_q, err_d;
  logic mism_q, mism_d;
  logic verify_q, verify_d;
  logic [1:0] path_q, path_d;
  logic [2:0] ibp_q, ibp_d;
  logic [NUM_PORTS-1:0] mask_q, mask_d;
  logic wr;
  logic [7:0] wofs;
  logic [31:0] wdata;
  logic start;
  logic [4:0] k;
  logic [31:0] ent;
  logic [31:0] sw;
  logic [15:0] cmp_mask;
  logic [2:0] np;

  ahb_cfg_slave u_slave (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .o_wr(wr),
    .o_wofs(wofs),
    .o_wdata(wdata),
    .i_rd_ctrl({25'h0, verify_q, ibp_q, path_q, 1'b0}),
    .i_rd_status({20'h0, step_q, port_q, mism_q, err_q, done_q, busy_q}),
    .i_rd_mask({{(32 - NUM_PORTS){1'b0}}, mask_q})
  );

  // lowest selected port above cur, zero when none is left
  function automatic logic [2:0] next_port(input logic [2:0] cur, input logic [NUM_PORTS-1:0] msk);
    logic [2:0] r;
    r = 3'h0;
    for (int p = NUM_PORTS; p >= 1; p--) begin
      if (msk[p-1] && 3'(p) > cur)
        r = 3'(p);
    end
    return r;
  endfunction : next_port

  // address and data of one sequence step of one port
  function automatic logic [31:0] step_word(input logic [2:0] p, input logic [4:0] s);
    logic [4:0] j;
    logic [31:0] e;
    j = s - 5'h1;
    e = phy_init_pkg::mmd_entry(j[4:2]);
    if (s == 5'h0)
      return {phy_init_pkg::phy_addr(p, phy_init_pkg::REG_BASIC_CTRL), phy_init_pkg::CTRL_FORCE_100FD};
    if (s == phy_init_pkg::STEP_LAST)
      return {phy_init_pkg::phy_addr(p, phy_init_pkg::REG_BASIC_CTRL), phy_init_pkg::CTRL_AN_RESTART};
    case (j[1:0])
      2'h0: return {phy_init_pkg::phy_addr(p, phy_init_pkg::REG_MMD_SETUP),
                    phy_init_pkg::MMD_FN_ADDR, 6'h00, e[31:24]};
      2'h1: return {phy_init_pkg::phy_addr(p, phy_init_pkg::REG_MMD_DATA), 8'h00, e[23:16]};
      2'h2: return {phy_init_pkg::phy_addr(p, phy_init_pkg::REG_MMD_SETUP),
                    phy_init_pkg::MMD_FN_DATA, 6'h00, e[31:24]};
      default: return {phy_init_pkg::phy_addr(p, phy_init_pkg::REG_MMD_DATA), e[15:0]};
    endcase
  endfunction : step_word

  always_comb begin
    start = wr & (wofs == phy_init_pkg::OFS_CTRL) & wdata[0];
    k = step_q - 5'h1;
    ent = phy_init_pkg::mmd_entry(k[4:2]);
    sw = step_word(port_q, step_q);
    cmp_mask = 16'hffff;
    if (ent[31:24] == phy_init_pkg::MMD_DEV_VEND && ent[23:16] == phy_init_pkg::MMD_UNFIXED_REG)
      cmp_mask = 16'hfffe;
    np = next_port(port_q, mask_q);
    // configuration registers; changes while busy apply at once to the run under way
    path_d = path_q;
    ibp_d = ibp_q;
    verify_d = verify_q;
    mask_d = mask_q;
    if (wr && wofs == phy_init_pkg::OFS_CTRL) begin
      path_d = wdata[2:1];
      ibp_d = wdata[5:3];
      verify_d = wdata[6];
    end
    if (wr && wofs == phy_init_pkg::OFS_PORT_MASK)
      mask_d = wdata[NUM_PORTS-1:0];
    state_d = state_q;
    port_d = port_q;
    step_d = step_q;
    rd_d = rd_q;
    req_d = req_q;
    we_d = we_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    busy_d = busy_q;
    done_d = done_q;
    err_d = err_q;
    mism_d = mism_q;
    case (state_q)
      ST_IDLE: begin
        // start is ignored while a run is under way
        if (start) begin
          done_d = 1'b0;
          err_d = 1'b0;
          mism_d = 1'b0;
          busy_d = 1'b1;
          port_d = next_port(3'h0, mask_d);
          step_d = 5'h0;
          rd_d = 1'b0;
          state_d = (next_port(3'h0, mask_d) == 3'h0) ? ST_END : ST_REQ;
        end
      end
      ST_REQ: begin
        req_d = 1'b1;
        we_d = ~rd_q;
        addr_d = sw[31:16];
        wdata_d = sw[15:0];
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (m.ack) begin
          req_d = 1'b0;
          if (m.err) begin
            err_d = 1'b1;
            busy_d = 1'b0;
            state_d = ST_IDLE;
          end else if (!rd_q && verify_q && step_q != 5'h0 && step_q != phy_init_pkg::STEP_LAST
                       && k[1:0] == 2'h3) begin
            rd_d = 1'b1;
            state_d = ST_REQ;
          end else begin
            if (rd_q && ((m.rdata ^ ent[15:0]) & cmp_mask) != 16'h0000)
              mism_d = 1'b1;
            rd_d = 1'b0;
            state_d = ST_REQ;
            if (step_q == phy_init_pkg::STEP_LAST) begin
              step_d = 5'h0;
              port_d = np;
              if (np == 3'h0)
                state_d = ST_END;
            end else begin
              step_d = step_q + 5'h1;
            end
          end
        end
      end
      ST_END: begin
        busy_d = 1'b0;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      port_q <= 3'h0;
      step_q <= 5'h0;
      rd_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      mism_q <= 1'b0;
      verify_q <= 1'b0;
      path_q <= phy_init_pkg::CTRL_PATH_RST;
      ibp_q <= phy_init_pkg::INBAND_PORT_DEF;
      mask_q <= NUM_PORTS'(phy_init_pkg::PORT_MASK_RST);
    end else begin
      state_q <= state_d;
      port_q <= port_d;
      step_q <= step_d;
      rd_q <= rd_d;
      req_q <= req_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      busy_q <= busy_d;
      done_q <= done_d;
      err_q <= err_d;
      mism_q <= mism_d;
      verify_q <= verify_d;
      path_q <= path_d;
      ibp_q <= ibp_d;
      mask_q <= mask_d;
    end
  end

  assign m.req = req_q;
  assign m.we = we_q;
  assign m.addr = addr_q;
  assign m.wdata = wdata_q;
  assign m.path = phy_init_pkg::mgmt_path_t'(path_q);
  assign m.ib_port = ibp_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
endmodule : phy_init_host

// [verification/phy_errata_init_sequencer_assertions.sv]
// concurrent checks on the management link between the sequencer and the switch
`timescale 1ns/1ps
module phy_errata_init_sequencer_assertions (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // management link
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire phy_init_pkg::mgmt_path_t path,
  input wire logic [2:0] ib_port,
  input wire logic ack,
  input wire logic err,
  input wire logic [15:0] rdata
);
  logic open_q;
  logic open_d;
  logic [2:0] port_q;
  logic [2:0] port_d;
  wire ctl = req && we && (addr[5:0] == 6'h00);
  wire mmd = req && we && (addr[5:0] inside {6'h1a, 6'h1c});

  // forced window: opened by an accepted 2100 write, closed by the restart write
  always_comb begin
    open_d = open_q;
    port_d = port_q;
    if (ctl && ack && !err && wdata == 16'h2100) begin
      open_d = 1'b1;
      port_d = addr[14:12];
    end else if (ctl && ack && wdata == 16'h1340) begin
      open_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      open_q <= 1'b0;
      port_q <= 3'h0;
    end else begin
      open_q <= open_d;
      port_q <= port_d;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_next: assert property (req && !ack |=> ack)
    else $error("request not answered next cycle");
  a_req_release: assert property (ack |=> !req)
    else $error("request held after ack");
  // the host may raise the next request after a single idle cycle, so only the drop itself is checked
  a_req_until_ack: assert property ($fell(req) |-> $past(ack))
    else $error("request dropped before ack");
  a_req_hold: assert property (req && !ack |=> $stable({we, addr, wdata, path, ib_port}))
    else $error("request changed while pending");
  a_addr_window: assert property (req |-> !addr[15] && addr[11:6] == 6'h04 && !addr[0]
                                   && addr[14:12] inside {[3'h1:3'h5]})
    else $error("address outside phy window");
  a_reg_pair: assert property (req |-> addr[5:0] inside {6'h00, 6'h1a, 6'h1c})
    else $error("access outside control and indirect pair");
  a_ctl_values: assert property (ctl |-> wdata inside {16'h2100, 16'h1340})
    else $error("unexpected basic control value");
  a_mmd_forced: assert property (mmd |-> open_q && addr[14:12] == port_q)
    else $error("indirect write without forced mode");
  a_restart_last: assert property (ctl && wdata == 16'h1340 |-> open_q && addr[14:12] == port_q)
    else $error("restart without prior forced mode");
  a_err_ack: assert property (err |-> ack)
    else $error("err without ack");

  c_refused: cover property (ack && err);
  c_readback: cover property (ack && !we);
  c_restart: cover property (ctl && ack && wdata == 16'h1340);
endmodule : phy_errata_init_sequencer_assertions

// [verification/phy_errata_init_sequencer_bench.sv]
// self-checking bench: ahb master starts runs, link traffic scored against the tuning list
`timescale 1ns/1ps
module phy_errata_init_sequencer_bench;
  typedef struct packed {logic we; logic err; logic [15:0] addr; logic [15:0] data;} note_t;
  logic i_mclk, i_rst, hsel, hwrite, hready, hresp, busy, done, mmd_wr;
  logic [31:0] haddr, hwdata, hrdata, rd, rnd, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] an_en, an_rs;
  int error_cnt, samples_checked, rs_cnt, mw_cnt;
  note_t q[$];
  note_t nt;
  logic [15:0] rmask;
  logic [31:0] tbl [7] = '{32'h016fdd0b, 32'h018f6032, 32'h019d248c, 32'h01750060,
                           32'h01d37777, 32'h1c063008, 32'h1c082000};

  mgmt_if u_mgmt_if ();
  phy_init_host u_phy_init_host (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .m(u_mgmt_if.cfg), .o_busy(busy),
    .o_done(done));
  phy_cfg_device u_phy_cfg_device (.i_mclk(i_mclk), .i_rst(i_rst), .m(u_mgmt_if.dev),
    .o_an_enable(an_en), .o_an_restart(an_rs), .o_mmd_wr(mmd_wr));
  phy_errata_init_sequencer_assertions u_phy_errata_init_sequencer_assertions (.i_mclk(i_mclk),
    .i_rst(i_rst), .req(u_mgmt_if.req), .we(u_mgmt_if.we), .addr(u_mgmt_if.addr),
    .wdata(u_mgmt_if.wdata), .path(u_mgmt_if.path), .ib_port(u_mgmt_if.ib_port),
    .ack(u_mgmt_if.ack), .err(u_mgmt_if.err), .rdata(u_mgmt_if.rdata));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [15:0] pa(input int p, input logic [4:0] r);
    return {1'b0, p[2:0], 12'h100} | {10'h000, r, 1'b0};
  endfunction : pa

  task automatic note(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e);
    q.push_back({w, e, a, d});
  endtask : note

  // waits for hready at a rising edge; the bound only catches a hung slave
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1) begin
      error_cnt++;
      test_done();
    end
  endtask : hwait

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge i_mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : xfer

  task automatic run(input logic [4:0] mask, input logic [1:0] path, input logic [2:0] ibp,
                     input logic vfy, input logic bad);
    int rs0, mw0, np, n;
    rs0 = rs_cnt;
    mw0 = mw_cnt;
    np = 0;
    xfer(1'b1, 32'h08, {27'h0, mask});
    for (int p = 1; p <= 5; p++) begin
      if (mask[p-1]) begin
        np++;
        note(1'b1, pa(p, 5'h00), 16'h2100, bad);
        for (int e = 0; e < 7 && !bad; e++) begin
          note(1'b1, pa(p, 5'h0d), {8'h00, tbl[e][31:24]}, 1'b0);
          note(1'b1, pa(p, 5'h0e), {8'h00, tbl[e][23:16]}, 1'b0);
          note(1'b1, pa(p, 5'h0d), {8'h40, tbl[e][31:24]}, 1'b0);
          note(1'b1, pa(p, 5'h0e), tbl[e][15:0], 1'b0);
          if (vfy) note(1'b0, pa(p, 5'h0e), tbl[e][15:0], 1'b0);
        end
        if (!bad) note(1'b1, pa(p, 5'h00), 16'h1340, 1'b0);
      end
    end
    xfer(1'b1, 32'h00, {25'h0, vfy, ibp, path, 1'b1});
    n = 0;
    do begin
      xfer(1'b0, 32'h04, 32'h0);
      n++;
    end while (rd[2:1] === 2'h0 && n < 3000);
    if (n >= 3000) begin
      error_cnt++;
      test_done();
    end
    repeat (2) @(posedge i_mclk);
    chk("status", {28'h0, 1'b0, bad, !bad, 1'b0}, {28'h0, rd[3:0]});
    chk("busy done", {30'h0, 1'b0, !bad}, {30'h0, busy, done});
    chk("pending notes", 32'h0, q.size());
    chk("restarts", bad ? 32'h0 : np, rs_cnt - rs0);
    chk("mmd writes", bad ? 32'h0 : 7 * np, mw_cnt - mw0);
    chk("an enable", 32'h1f, {27'h0, an_en});
  endtask : run

  // scoreboard: every answered link access must match the oldest note
  always @(posedge i_mclk) begin
    rs_cnt += $countones(an_rs);
    mw_cnt += 32'(mmd_wr);
    if (!i_rst && u_mgmt_if.ack === 1'b1) begin
      if (q.size() == 0) begin
        chk("unexpected access", 32'h0, {16'h0, u_mgmt_if.addr});
      end else begin
        nt = q.pop_front();
        chk("req", 32'h1, {31'h0, u_mgmt_if.req});
        chk("we", {31'h0, nt.we}, {31'h0, u_mgmt_if.we});
        chk("addr", {16'h0, nt.addr}, {16'h0, u_mgmt_if.addr});
        chk("err", {31'h0, nt.err}, {31'h0, u_mgmt_if.err});
        if (nt.we) begin
          chk("wdata", {16'h0, nt.data}, {16'h0, u_mgmt_if.wdata});
          // basic control lands at the edge that raises ack, so the new enable is visible here
          if (nt.addr[5:0] == 6'h00 && !nt.err) begin
            chk("an enable", {31'h0, nt.data[12]}, {31'h0, an_en[nt.addr[14:12] - 3'h1]});
          end
        end else begin
          // only the unfixed register's entry 2000 may come back with bit 0 set
          rmask = (nt.data == 16'h2000) ? 16'hfffe : 16'hffff;
          chk("rdata", {16'h0, nt.data & rmask}, {16'h0, u_mgmt_if.rdata & rmask});
        end
      end
    end
  end

  initial begin
    i_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    seed = 32'h5f;
    error_cnt = 0;
    samples_checked = 0;
    rs_cnt = 0;
    mw_cnt = 0;
    rmask = 16'hffff;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    chk("an enable reset", 32'h1f, {27'h0, an_en});
    xfer(1'b0, 32'h00, 32'h0);
    chk("ctrl reset", 32'h38, rd);
    xfer(1'b0, 32'h08, 32'h0);
    chk("mask reset", 32'h1f, rd);
    xfer(1'b1, 32'h0c, 32'hffffffff);
    xfer(1'b0, 32'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    run(5'h1f, 2'h0, 3'h7, 1'b1, 1'b0);
    for (int k = 0; k < 4; k++) begin
      rnd = xs();
      run((rnd[4:0] == 5'h0) ? 5'h10 : rnd[4:0], k[1:0], 3'h7, rnd[5], 1'b0);
    end
    run(5'h00, 2'h1, 3'h7, 1'b0, 1'b0);
    // in-band from a port other than the default one must be refused
    run(5'h04, 2'h3, 3'h6, 1'b0, 1'b1);
    run(5'h02, 2'h3, 3'h7, 1'b1, 1'b0);
    test_done();
  end
endmodule : phy_errata_init_sequencer_bench
